/* File: fcs_pkg.sv */
package fcs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WA_W = 15;

  // Register indices; the byte address is four times the index
  localparam logic [1:0] IDX_SCAN_CONTROL_A = 2'h0;
  localparam logic [1:0] IDX_SCAN_CONTROL_B = 2'h1;
  localparam logic [1:0] IDX_SCAN_STATUS = 2'h2;
  localparam logic [9:0] NUM_REGS = 10'h003;

  // Field positions
  localparam int unsigned CA_ENABLE_BIT = 0;
  localparam int unsigned CA_IRQ_EN_BIT = 1;
  localparam int unsigned CA_SOFT_RST_BIT = 7;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_OK_BIT = 1;

  // Reset values
  localparam logic [7:0] SCAN_CONTROL_A_RST = 8'h00;
  localparam logic [7:0] SCAN_CONTROL_B_RST = 8'h00;
  localparam logic [7:0] SCAN_STATUS_RST = 8'h02;

  // Timing counts in clock cycles
  localparam logic [1:0] START_DELAY_CYC = 2'h3;
  localparam logic [1:0] FETCH_PERIOD_CYC = 2'h3;

  // Checksum
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  typedef enum logic [1:0] {
    SEC_WHOLE_FLASH = 2'h0,
    SEC_BOOT_PLUS_APP = 2'h1,
    SEC_BOOT = 2'h2,
    SEC_SIGNATURE_ROW = 2'h3
  } fcs_section_e;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SCAN, ST_CHECK} fcs_state_e;

  // Last word address of each section, from the fuse logic
  typedef struct packed {
    logic [WA_W-1:0] flash_end;
    logic [WA_W-1:0] boot_app_end;
    logic [WA_W-1:0] boot_end;
    logic [WA_W-1:0] signature_row_end;
  } fcs_sect_ends_s;

  typedef struct packed {
    logic rd_en;
    logic signature_row;
    logic [WA_W-1:0] addr;
  } fcs_flash_req_s;

  function automatic logic [15:0] fcs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ b[i])
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

endpackage

/* File: fcs_crc16.sv */
module fcs_crc16
  import fcs_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic clear, // Load initial value
  input wire logic feed, // Absorb one word
  input wire logic [15:0] word, // Flash word, low byte is first
  output logic [15:0] crc // Running checksum
);

  logic [15:0] crc_r;

  assign crc = crc_r;

  // Low byte sits at the even address, so it goes in first, MSB first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crc_r <= CRC_INIT;
    else if (clear)
      crc_r <= CRC_INIT;
    else if (feed)
      crc_r <= fcs_crc_byte(fcs_crc_byte(crc_r, word[7:0]), word[15:8]);
  end

endmodule

/* File: fcs_scan_ctrl.sv */
// How it works
// - Scanning halts while the processor sleeps and resumes on wake.
// - Scan begins three cycles after enable is set; processor keeps running.
// - Sleep during the start delay holds off the scan until wake.
// - After such a wake, interrupts are held back until the scan ends.
// - Once the failure interrupt fires, control A writes are ignored.
// - Soft reset clears enable, control B and status one cycle after the write.
// - Soft-reset bit is a self-clearing strobe, never stored.
// - Without failure interrupt enabled, soft reset works even when busy.
// - With failure interrupt enabled, soft reset only works when idle.
// - A mismatch raises the failure interrupt when it is enabled.
// - Failure interrupt enable clears only on system reset, not soft reset.
// - Failure interrupt enable can be set only while idle.
// - Writing enable one starts a check; the bit stays one afterwards.
// - Writing enable zero does not abort; scan runs to section end.
// - A failure after enable was cleared is still caught and reported.
// - A scan started during reset init leaves enable reading one.
// - Control B writes ignored while busy or after the interrupt.
// - Section select: whole flash, boot plus app, boot, signature row.
// - A reset-init scan leaves section select showing the checked section.
// - Status is read only, resets to 0x02, writes do nothing.
// - Pass flag: one at reset, cleared on enable, set on good check.
// - Busy reads one during a check; control writes are restricted.
// - CCITT 16-bit checksum from all ones; residue zero means pass.
// - Scanner owns flash, stalls processor, fetches a word every third cycle.
// - Failure clears pass flag; interrupt request holds until system reset.
//
// Local design decision: the APB interface to the registers.
module fcs_scan_ctrl
  import fcs_pkg::*;
(
  input wire logic pclk, // APB clock, 20 MHz
  input wire logic presetn, // System reset, async, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic cpu_sleep, // Processor is in a sleep mode
  input wire logic boot_scan_start, // Pulse: scan requested by reset init
  input wire logic [1:0] boot_scan_section, // Section for the reset-init scan
  input wire fcs_sect_ends_s sect_ends, // Last word address of each section
  output fcs_flash_req_s flash_req, // Word fetch request
  input wire logic [15:0] flash_rdata, // Word, valid the cycle after rd_en
  output logic cpu_stall, // Hold the processor off flash
  output logic cpu_irq_hold, // Defer interrupt handling
  output logic nmi_req // Non-maskable failure request
);

  fcs_state_e st_r;
  logic [1:0] cnt_r;
  logic [WA_W-1:0] wa_r;
  logic en_r;
  logic irq_en_r;
  logic [1:0] section_select_r;
  logic busy_r;
  logic ok_r;
  logic nmi_r;
  logic soft_rst_r;
  logic defer_r;
  logic [31:0] prdata_r;
  fcs_flash_req_s flash_req_r;
  logic [15:0] crc;
  logic wr_acc;
  logic hit;
  logic [1:0] idx;
  logic wr_a;
  logic wr_b;
  logic soft_acc;
  logic start_sw;
  logic start_acc;
  logic feed;
  logic last_word;

  function automatic logic idx_valid(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (a[11:2] < NUM_REGS);
  endfunction

  function automatic logic [WA_W-1:0] sect_end(input logic [1:0] s, input fcs_sect_ends_s e);
    logic [WA_W-1:0] r;
    unique case (fcs_section_e'(s))
      SEC_WHOLE_FLASH: r = e.flash_end;
      SEC_BOOT_PLUS_APP: r = e.boot_app_end;
      SEC_BOOT: r = e.boot_end;
      SEC_SIGNATURE_ROW: r = e.signature_row_end;
    endcase
    return r;
  endfunction

  // Zero-wait slave: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign hit = idx_valid(paddr);
  assign idx = paddr[3:2];
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;
  assign wr_acc = psel && penable && pwrite && hit;
  assign wr_a = wr_acc && (idx == IDX_SCAN_CONTROL_A);
  assign wr_b = wr_acc && (idx == IDX_SCAN_CONTROL_B);

  // All control A effects are blocked once the interrupt has fired
  assign soft_acc = wr_a && !nmi_r && pwdata[CA_SOFT_RST_BIT]
                    && (!irq_en_r || !busy_r);
  assign start_sw = wr_a && !nmi_r && pwdata[CA_ENABLE_BIT] && !busy_r;
  assign start_acc = !soft_rst_r && (start_sw || (boot_scan_start && !busy_r));

  assign feed = (st_r == ST_SCAN) && (cnt_r == 2'h2);
  assign last_word = wa_r == sect_end(section_select_r, sect_ends);

  assign flash_req = flash_req_r;
  assign cpu_stall = (st_r == ST_SCAN) || (st_r == ST_CHECK);
  assign cpu_irq_hold = defer_r;
  assign nmi_req = nmi_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      prdata_r <= 32'h0000_0000;
      if (idx_valid(paddr))
      begin
        unique case (paddr[3:2])
          IDX_SCAN_CONTROL_A:
            begin
              prdata_r[CA_ENABLE_BIT] <= en_r;
              prdata_r[CA_IRQ_EN_BIT] <= irq_en_r;
            end
          IDX_SCAN_CONTROL_B:
            prdata_r[1:0] <= section_select_r;
          IDX_SCAN_STATUS:
            begin
              prdata_r[ST_BUSY_BIT] <= busy_r;
              prdata_r[ST_OK_BIT] <= ok_r && !busy_r;
            end
          default:
            prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Strobe lives one cycle, so the clear lands one cycle after the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= soft_acc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_r <= SCAN_CONTROL_A_RST[CA_ENABLE_BIT];
    else if (soft_rst_r)
      en_r <= 1'b0;
    else if (boot_scan_start && !busy_r)
      en_r <= 1'b1;
    else if (wr_a && !nmi_r)
      en_r <= pwdata[CA_ENABLE_BIT];
  end

  // Only a system reset clears the interrupt enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_r <= SCAN_CONTROL_A_RST[CA_IRQ_EN_BIT];
    else if (wr_a && !nmi_r && !busy_r && pwdata[CA_IRQ_EN_BIT])
      irq_en_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      section_select_r <= SCAN_CONTROL_B_RST[1:0];
    else if (soft_rst_r)
      section_select_r <= 2'h0;
    else if (boot_scan_start && !busy_r)
      section_select_r <= boot_scan_section;
    else if (wr_b && !busy_r && !nmi_r)
      section_select_r <= pwdata[1:0];
  end

  // Sequencer: start delay, fetch phases, final check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 2'h0;
      wa_r <= '0;
    end
    else if (soft_rst_r)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 2'h0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
          if (start_acc)
          begin
            st_r <= ST_DELAY;
            cnt_r <= 2'h0;
            wa_r <= '0;
          end
        ST_DELAY:
          if (!cpu_sleep)
          begin
            if (cnt_r == START_DELAY_CYC - 2'h1)
            begin
              st_r <= ST_SCAN;
              cnt_r <= 2'h0;
            end
            else
              cnt_r <= cnt_r + 2'h1;
          end
        ST_SCAN:
          // Sleep freezes only before a fetch, so no word in flight is lost
          if (cnt_r != 2'h0 || !cpu_sleep)
          begin
            if (cnt_r == FETCH_PERIOD_CYC - 2'h1)
            begin
              cnt_r <= 2'h0;
              if (last_word)
                st_r <= ST_CHECK;
              else
                wa_r <= wa_r + 1'b1;
            end
            else
              cnt_r <= cnt_r + 2'h1;
          end
        ST_CHECK:
          st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_req_r <= '0;
    else
    begin
      flash_req_r.rd_en <= !soft_rst_r && (st_r == ST_SCAN) && (cnt_r == 2'h0)
                           && !cpu_sleep;
      flash_req_r.addr <= wa_r;
      flash_req_r.signature_row <= section_select_r == SEC_SIGNATURE_ROW;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_r <= SCAN_STATUS_RST[ST_BUSY_BIT];
    else if (soft_rst_r)
      busy_r <= 1'b0;
    else if (start_acc)
      busy_r <= 1'b1;
    else if (st_r == ST_CHECK)
      busy_r <= 1'b0;
  end

  // Status is never written from the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ok_r <= SCAN_STATUS_RST[ST_OK_BIT];
    else if (soft_rst_r)
      ok_r <= 1'b0;
    else if (start_acc)
      ok_r <= 1'b0;
    else if (st_r == ST_CHECK)
      ok_r <= crc == CRC_RESIDUE;
  end

  // Held until system reset; a failing tail after enable cleared still counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_r <= 1'b0;
    else if (st_r == ST_CHECK && crc != CRC_RESIDUE && irq_en_r)
      nmi_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      defer_r <= 1'b0;
    else if (soft_rst_r || st_r == ST_CHECK)
      defer_r <= 1'b0;
    else if (st_r == ST_DELAY && cpu_sleep)
      defer_r <= 1'b1;
  end

  fcs_crc16 u_crc
  (
    .pclk(pclk),
    .presetn(presetn),
    .clear(start_acc),
    .feed(feed),
    .word(flash_rdata),
    .crc(crc)
  );

  sequence s_start;
    st_r == ST_IDLE && start_acc;
  endsequence

  sequence s_awake_delay;
    (!cpu_sleep && !soft_rst_r)[*3];
  endsequence

  property p_start_delay;
    @(posedge pclk) disable iff (!presetn)
    s_start ##1 s_awake_delay |=> st_r == ST_SCAN;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("scan not started after delay");

  property p_sleep_holds_start;
    @(posedge pclk) disable iff (!presetn)
    st_r == ST_DELAY && cpu_sleep && !soft_rst_r |=> st_r == ST_DELAY && defer_r;
  endproperty
  a_sleep_holds_start: assert property (p_sleep_holds_start) else $error("started in sleep");

  property p_soft_clear;
    @(posedge pclk) disable iff (!presetn)
    soft_acc |=> ##1 !en_r && section_select_r == 2'h0 && !busy_r && !ok_r;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear");

  property p_locked_after_nmi;
    @(posedge pclk) disable iff (!presetn)
    nmi_r && wr_a |=> $stable(en_r) && !soft_rst_r;
  endproperty
  a_locked_after_nmi: assert property (p_locked_after_nmi) else $error("control A written");

  property p_irq_en_survives;
    @(posedge pclk) disable iff (!presetn)
    irq_en_r |=> irq_en_r;
  endproperty
  a_irq_en_survives: assert property (p_irq_en_survives) else $error("irq enable lost");

  property p_nmi_sticky;
    @(posedge pclk) disable iff (!presetn)
    nmi_r |=> nmi_r;
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi request dropped");

  property p_ctrl_b_locked;
    @(posedge pclk) disable iff (!presetn)
    wr_b && (busy_r || nmi_r) && !soft_rst_r |=> $stable(section_select_r);
  endproperty
  a_ctrl_b_locked: assert property (p_ctrl_b_locked) else $error("control B written");

  property p_fetch_spacing;
    @(posedge pclk) disable iff (!presetn)
    flash_req_r.rd_en |=> !flash_req_r.rd_en ##1 !flash_req_r.rd_en;
  endproperty
  a_fetch_spacing: assert property (p_fetch_spacing) else $error("fetch too soon");

  property p_ok_cleared_on_start;
    @(posedge pclk) disable iff (!presetn)
    start_acc |=> !ok_r && busy_r;
  endproperty
  a_ok_cleared_on_start: assert property (p_ok_cleared_on_start) else $error("ok not cleared");

  property p_no_fetch_asleep;
    @(posedge pclk) disable iff (!presetn)
    cpu_sleep && st_r == ST_SCAN && cnt_r == 2'h0 |=> !flash_req_r.rd_en;
  endproperty
  a_no_fetch_asleep: assert property (p_no_fetch_asleep) else $error("fetch while asleep");

endmodule

/* File: fcs_flash_model.sv */
module fcs_flash_model
  import fcs_pkg::*;
(
  input wire logic pclk, // Clock
  input wire fcs_flash_req_s flash_req, // Fetch request
  input wire logic corrupt, // Flip a bit of word 0
  output logic [15:0] flash_rdata // Word, one cycle after the request
);
  logic [15:0] mem [16];
  logic [15:0] sig [4];
  logic [15:0] crc;

  // Own checksum so the bench never leans on the design's function
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    logic [15:0] d;
    r = c;
    d = {w[7:0], w[15:8]};
    for (int i = 15; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction

  // Checksum high byte at the even byte of each section's last word
  initial
  begin
    flash_rdata = 16'h0000;
    crc = 16'hFFFF;
    for (int a = 0; a < 16; a++)
    begin
      if (a == 7 || a == 11 || a == 15)
        mem[a] = {crc[7:0], crc[15:8]};
      else
        mem[a] = (16'(a) * 16'h0123) ^ 16'h5A3C;
      crc = crc_word(crc, mem[a]);
    end
    crc = 16'hFFFF;
    for (int a = 0; a < 4; a++)
    begin
      sig[a] = (a == 3) ? {crc[7:0], crc[15:8]} : 16'(a) ^ 16'hC3A5;
      crc = crc_word(crc, sig[a]);
    end
  end

  // Stale data toggles so a late sample never matches by luck
  always @(posedge pclk)
  begin
    if (flash_req.rd_en)
      flash_rdata <= (flash_req.signature_row ? sig[flash_req.addr[1:0]]
        : mem[flash_req.addr[3:0]]) ^ {15'h0000, corrupt && flash_req.addr == '0};
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule

/* File: flash_crc_scan_control_tb_top.sv */
module flash_crc_scan_control_tb_top import fcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cpu_sleep, boot_scan_start, cpu_stall, cpu_irq_hold, nmi_req, corrupt;
  logic [1:0] boot_scan_section;
  logic [15:0] flash_rdata;
  fcs_sect_ends_s sect_ends;
  fcs_flash_req_s flash_req;
  int num_errors = 0;
  int n_checks = 0;
  // Which design output bit_at samples after its wait
  localparam int S_STALL = 0;
  localparam int S_HOLD = 1;
  localparam int S_NMI = 2;

  assign sect_ends = {15'h000F, 15'h000B, 15'h0007, 15'h0003};

  fcs_scan_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_sleep(cpu_sleep), .boot_scan_start(boot_scan_start),
    .boot_scan_section(boot_scan_section), .sect_ends(sect_ends), .flash_req(flash_req),
    .flash_rdata(flash_rdata), .cpu_stall(cpu_stall), .cpu_irq_hold(cpu_irq_hold),
    .nmi_req(nmi_req));

  fcs_flash_model u_flash (.pclk(pclk), .flash_req(flash_req), .corrupt(corrupt),
    .flash_rdata(flash_rdata));

  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic print_verdict();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t no ready", $time);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] i, input logic [7:0] e, input string m);
    logic [31:0] r;
    apb(1'b0, {8'h00, i, 2'b00}, 8'h00, r);
    chk(r, {24'h000000, e}, m);
  endtask

  task automatic wr(input logic [1:0] i, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, {8'h00, i, 2'b00}, d, r);
  endtask

  // Read the output only after the wait, not when the task is called
  function automatic logic pick(input int k);
    case (k)
      S_STALL: return cpu_stall;
      S_HOLD: return cpu_irq_hold;
      default: return nmi_req;
    endcase
  endfunction

  task automatic bit_at(input int n, input int k, input logic e, input string m);
    repeat (n) @(posedge pclk);
    #1;
    chk({31'h0, pick(k)}, {31'h0, e}, m);
  endtask

  task automatic wait_idle();
    logic [31:0] r;
    int n;
    r = 32'h1;
    for (n = 0; n < 300 && r[0] !== 1'b0; n++)
      apb(1'b0, {8'h00, IDX_SCAN_STATUS, 2'b00}, 8'h00, r);
    chk({31'h0, r[0]}, 32'h0, "busy stuck");
  endtask

  task automatic t_regs();
    logic [31:0] r;
    rd(IDX_SCAN_CONTROL_A, 8'h00, "A rst");
    rd(IDX_SCAN_CONTROL_B, 8'h00, "B rst");
    rd(IDX_SCAN_STATUS, 8'h02, "S rst");
    apb(1'b0, 12'h00C, 8'h00, r);
    chk({31'h0, perr}, 32'h1, "unmapped");
    wr(IDX_SCAN_STATUS, 8'hFF);
    rd(IDX_SCAN_STATUS, 8'h02, "S write");
    wr(IDX_SCAN_CONTROL_B, 8'hFF);
    rd(IDX_SCAN_CONTROL_B, 8'h03, "B unused");
  endtask

  task automatic t_sections();
    for (int s = 0; s < 4; s++)
    begin
      wr(IDX_SCAN_CONTROL_B, 8'(s));
      rd(IDX_SCAN_CONTROL_B, 8'(s), "B sec");
      wr(IDX_SCAN_CONTROL_A, 8'h01);
      bit_at(0, S_STALL, 1'b0, "stall early");
      bit_at(2, S_STALL, 1'b0, "stall early");
      bit_at(1, S_STALL, 1'b1, "stall late");
      rd(IDX_SCAN_STATUS, 8'h01, "S busy");
      wr(IDX_SCAN_CONTROL_B, 8'(s ^ 1));
      rd(IDX_SCAN_CONTROL_B, 8'(s), "B busy");
      wr(IDX_SCAN_CONTROL_A, 8'h03);
      rd(IDX_SCAN_CONTROL_A, 8'h01, "irq en busy");
      wait_idle();
      rd(IDX_SCAN_STATUS, 8'h02, "S pass");
      rd(IDX_SCAN_CONTROL_A, 8'h01, "A en");
    end
  endtask

  task automatic t_sleep();
    int n;
    wr(IDX_SCAN_CONTROL_B, 8'h00);
    wr(IDX_SCAN_CONTROL_A, 8'h01);
    cpu_sleep <= 1'b1;
    bit_at(8, S_STALL, 1'b0, "start in sleep");
    chk({31'h0, cpu_irq_hold}, 32'h1, "hold");
    @(posedge pclk);
    cpu_sleep <= 1'b0;
    for (n = 0; n < 10 && cpu_stall !== 1'b1; n++)
      bit_at(1, S_HOLD, 1'b1, "wake");
    bit_at(0, S_STALL, 1'b1, "no start");
    bit_at(6, S_HOLD, 1'b1, "hold scan");
    @(posedge pclk);
    cpu_sleep <= 1'b1;
    repeat (60) @(posedge pclk);
    rd(IDX_SCAN_STATUS, 8'h01, "frozen");
    @(posedge pclk);
    cpu_sleep <= 1'b0;
    wait_idle();
    rd(IDX_SCAN_STATUS, 8'h02, "resume");
    bit_at(0, S_HOLD, 1'b0, "hold end");
  endtask

  task automatic t_soft();
    wr(IDX_SCAN_CONTROL_B, 8'h02);
    wr(IDX_SCAN_CONTROL_A, 8'h01);
    wr(IDX_SCAN_CONTROL_A, 8'h80);
    rd(IDX_SCAN_CONTROL_A, 8'h00, "soft A");
    rd(IDX_SCAN_CONTROL_B, 8'h00, "soft B");
    rd(IDX_SCAN_STATUS, 8'h00, "soft S");
    wr(IDX_SCAN_CONTROL_A, 8'h01);
    wait_idle();
    rd(IDX_SCAN_STATUS, 8'h02, "after soft");
  endtask

  task automatic t_boot();
    wr(IDX_SCAN_CONTROL_B, 8'h00);
    @(posedge pclk);
    boot_scan_start <= 1'b1;
    boot_scan_section <= 2'h2;
    @(posedge pclk);
    boot_scan_start <= 1'b0;
    wait_idle();
    rd(IDX_SCAN_CONTROL_A, 8'h01, "boot A");
    rd(IDX_SCAN_CONTROL_B, 8'h02, "boot B");
  endtask

  task automatic t_irq_soft();
    wr(IDX_SCAN_CONTROL_A, 8'h03);
    wr(IDX_SCAN_CONTROL_A, 8'h83);
    rd(IDX_SCAN_STATUS, 8'h01, "soft busy");
    wait_idle();
    wr(IDX_SCAN_CONTROL_A, 8'h80);
    rd(IDX_SCAN_CONTROL_A, 8'h02, "irq en kept");
    rd(IDX_SCAN_STATUS, 8'h00, "soft idle");
  endtask

  task automatic t_fail();
    corrupt <= 1'b1;
    wr(IDX_SCAN_CONTROL_A, 8'h03);
    wr(IDX_SCAN_CONTROL_A, 8'h02);
    rd(IDX_SCAN_STATUS, 8'h01, "no abort");
    wait_idle();
    rd(IDX_SCAN_STATUS, 8'h00, "fail");
    chk({31'h0, nmi_req}, 32'h1, "nmi");
    wr(IDX_SCAN_CONTROL_A, 8'h81);
    rd(IDX_SCAN_CONTROL_A, 8'h02, "A locked");
    wr(IDX_SCAN_CONTROL_B, 8'h01);
    rd(IDX_SCAN_CONTROL_B, 8'h00, "B locked");
    bit_at(20, S_NMI, 1'b1, "nmi held");
    @(posedge pclk);
    presetn <= 1'b0;
    bit_at(2, S_NMI, 1'b0, "nmi rst");
    @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SCAN_CONTROL_A, 8'h00, "A sysrst");
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cpu_sleep, boot_scan_start, corrupt} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    boot_scan_section = 2'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sections();
    t_sleep();
    t_soft();
    t_boot();
    t_irq_soft();
    t_fail();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #(20000 * CLK_PERIOD_NS);
    num_errors++;
    $display("BAD %0t timeout", $time);
    print_verdict();
  end
endmodule
